// File: logic/tweep_slave.v
// Summary of operation
// - SDA moves only while SCL low; SDA change with SCL high is start/stop.
// - SDA falling with SCL high is a start; commands need one first.
// - SDA rising with SCL high is a stop; after a read gives standby.
// - Words are 8 bits; device pulls SDA low on ninth clock to acknowledge.
// - Standby at power-up, and after stop once internal writes finish.
// - Each start is followed by an 8-bit device address word.
// - Top four device address bits must be 1010 to match.
// - Two bits match chip-select pins; third is page bit; lowest pin unused.
// - Eighth device address bit: one means read, zero means write.
// - Match gives acknowledge; mismatch releases SDA and waits for start.
// - Byte write: word address, one data byte, each acknowledged, then stop.
// - Stop after write starts timed write; no acknowledge while it runs.
// - Page write takes up to sixteen bytes before the closing stop.
// - Every received page write data byte is acknowledged.
// - Writes advance only low four address bits, wrapping within the page.
// - Polling address is acknowledged only after the write cycle ends.
// - Address counter keeps last accessed address plus one between accesses.
// - Reads wrap from the last byte of memory to the first.
// - Read address ack is followed by the byte at the counter address.
// - Master acknowledge fetches the next byte; no ack plus stop ends it.
// - 512-byte array, 9-bit address from page bit plus word address.
// - With write protect high the upper half of the array is kept.
`timescale 1ns/1ns
`default_nettype none
`include "tweep_defines.vh"

module tweep_slave #(
  parameter TWR_CYCLES = `TWEEP_TWR_CYC,
  parameter TWR_CW     = `TWEEP_TWR_CW
) (
  input  wire clk_in,
  input  wire rstn_in,
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_out,
  output wire sda_oe_out,
  input  wire chip_select_pin_high_in,
  input  wire chip_select_pin_low_in,
  input  wire wp_in,
  output wire busy_out,
  output wire standby_out
);

  localparam [2:0] ST_IDLE   = 3'h0;
  localparam [2:0] ST_DEVADR = 3'h1;
  localparam [2:0] ST_WADDR  = 3'h2;
  localparam [2:0] ST_WDATA  = 3'h3;
  localparam [2:0] ST_ACK    = 3'h4;
  localparam [2:0] ST_RDATA  = 3'h5;
  localparam [2:0] ST_RACK   = 3'h6;

  localparam [`TWEEP_ADDR_W-1:0] ADDR_ONE = 9'h001;
  localparam [`TWEEP_PAGE_W-1:0] LOW_ONE  = 4'h1;

  // Synchronised pin levels.
  wire [4:0] pins_f;
  wire       scl_f;
  wire       sda_f;
  wire       csh_f;
  wire       csl_f;
  wire       wp_f;

  reg                      scl_p_q;
  reg                      sda_p_q;
  reg  [2:0]               state_q;
  reg  [2:0]               next_q;
  reg  [1:0]               ph_q;
  reg  [2:0]               cnt_q;
  reg  [7:0]               sh_q;
  reg  [7:0]               obuf_q;
  reg                      oe_q;
  reg                      mack_q;
  reg  [`TWEEP_ADDR_W-1:0] addr_q;
  reg  [`TWEEP_PAGE_BYTES-1:0] valid_q;
  reg                      wr_go_q;
  reg                      standby_q;
  reg                      dev_page_q;

  reg  [7:0] mem_q  [0:(1<<`TWEEP_ADDR_W)-1];
  reg  [7:0] pbuf_q [0:`TWEEP_PAGE_BYTES-1];

  wire       busy;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_det;
  wire       stop_det;
  wire       rx_state;
  wire       byte_end;
  wire [7:0] rx_byte;
  wire [7:0] rd_byte;
  wire       dev_match;
  wire       commit;

  // All outside pins cross into the clock domain here; the pins idle
  // high, so the synchroniser resets to ones and no false start appears.
  tweep_sync #(
    .WIDTH (5),
    .INIT  (5'h1f)
  ) u_sync (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .pin_in    ({wp_in, chip_select_pin_low_in,
                 chip_select_pin_high_in, sda_in, scl_in}),
    .level_out (pins_f)
  );

  assign scl_f = pins_f[0];
  assign sda_f = pins_f[1];
  assign csh_f = pins_f[2];
  assign csl_f = pins_f[3];
  assign wp_f  = pins_f[4];

  // Internal write cycle timer; its length is the TWR_CYCLES parameter.
  tweep_wrtimer #(
    .CYCLES (TWR_CYCLES),
    .CW     (TWR_CW)
  ) u_wrtimer (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .start_in (wr_go_q),
    .busy_out (busy)
  );

  // Edge and condition detection on the filtered levels.
  assign scl_rise  = scl_f & ~scl_p_q;
  assign scl_fall  = ~scl_f & scl_p_q;
  assign start_det = scl_f & scl_p_q & sda_p_q & ~sda_f;
  assign stop_det  = scl_f & scl_p_q & ~sda_p_q & sda_f;

  // A byte is complete on the eighth rising edge of a receive state.
  assign rx_state = (state_q == ST_DEVADR) | (state_q == ST_WADDR) |
                    (state_q == ST_WDATA);
  assign rx_byte  = {sh_q[6:0], sda_f};
  assign byte_end = rx_state & scl_rise & (cnt_q == `TWEEP_BIT_LAST);

  // Address match: family code, both select pins, and no write running.
  // The page bit is not compared and the lowest select pin is not wired.
  assign dev_match =
    (rx_byte[`TWEEP_DEV_TYPE_HI:`TWEEP_DEV_TYPE_LO] == `TWEEP_DEV_TYPE) &
    (rx_byte[`TWEEP_DEV_CSH_BIT] == csh_f) &
    (rx_byte[`TWEEP_DEV_CSL_BIT] == csl_f) &
    ~busy;

  // Read data comes straight from the array at the counter.
  assign rd_byte = mem_q[addr_q];

  // A stop with buffered page data launches the nonvolatile write.
  assign commit = stop_det & (|valid_q);

  // Protocol engine. Start and stop win over any bit activity, because
  // the master may abort a transfer at any point with either.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      state_q   <= ST_IDLE;
      next_q    <= ST_IDLE;
      ph_q      <= 2'h0;
      cnt_q     <= 3'h0;
      sh_q      <= 8'h00;
      obuf_q    <= 8'h00;
      oe_q      <= 1'b0;
      mack_q    <= 1'b0;
      addr_q    <= `TWEEP_WADDR_RST;
      valid_q   <= `TWEEP_PBUF_RST;
      wr_go_q   <= 1'b0;
    end else begin
      scl_p_q <= scl_f;
      sda_p_q <= sda_f;
      wr_go_q <= commit;
      if (start_det) begin
        // A repeated start drops any page data not closed by a stop.
        state_q <= ST_DEVADR;
        cnt_q   <= 3'h0;
        ph_q    <= 2'h0;
        oe_q    <= 1'b0;
        valid_q <= `TWEEP_PBUF_RST;
      end else if (stop_det) begin
        state_q <= ST_IDLE;
        oe_q    <= 1'b0;
        valid_q <= `TWEEP_PBUF_RST;
      end else begin
        case (state_q)
          ST_DEVADR,
          ST_WADDR,
          ST_WDATA: begin
            if (scl_rise) begin
              sh_q  <= rx_byte;
              cnt_q <= cnt_q + 3'h1;
            end
            if (byte_end) begin
              ph_q <= 2'h0;
              if (state_q == ST_DEVADR) begin
                if (dev_match) begin
                  state_q <= ST_ACK;
                  if (rx_byte[`TWEEP_DEV_RW]) begin
                    next_q <= ST_RDATA;
                  end else begin
                    next_q <= ST_WADDR;
                  end
                end else begin
                  state_q <= ST_IDLE;
                end
              end else if (state_q == ST_WADDR) begin
                // Page bit from the device word plus the address byte;
                // a read that follows starts from this nine-bit value.
                addr_q  <= {dev_page_q, rx_byte};
                state_q <= ST_ACK;
                next_q  <= ST_WDATA;
              end else begin
                // Only the low four bits move, so the page wraps.
                addr_q[`TWEEP_PAGE_W-1:0] <=
                  addr_q[`TWEEP_PAGE_W-1:0] + LOW_ONE;
                valid_q[addr_q[`TWEEP_PAGE_W-1:0]] <= 1'b1;
                state_q <= ST_ACK;
                next_q  <= ST_WDATA;
              end
            end
          end
          ST_ACK: begin
            // First fall pulls SDA low for the ninth clock; second
            // fall releases it or puts out the first read bit.
            if (scl_fall) begin
              if (ph_q == 2'h0) begin
                oe_q <= 1'b1;
                ph_q <= 2'h1;
              end else begin
                cnt_q   <= 3'h0;
                state_q <= next_q;
                if (next_q == ST_RDATA) begin
                  oe_q   <= ~rd_byte[7];
                  obuf_q <= {rd_byte[6:0], 1'b0};
                  addr_q <= addr_q + ADDR_ONE;
                end else begin
                  oe_q <= 1'b0;
                end
              end
            end
          end
          ST_RDATA: begin
            // Bits change on the fall after each rise; the eighth
            // rise hands over to the master's acknowledge slot.
            if (scl_rise) begin
              cnt_q <= cnt_q + 3'h1;
              if (cnt_q == `TWEEP_BIT_LAST) begin
                state_q <= ST_RACK;
                ph_q    <= 2'h0;
              end
            end else if (scl_fall) begin
              oe_q   <= ~obuf_q[7];
              obuf_q <= {obuf_q[6:0], 1'b0};
            end
          end
          ST_RACK: begin
            if (scl_fall && ph_q == 2'h0) begin
              oe_q <= 1'b0;
              ph_q <= 2'h1;
            end else if (scl_rise && ph_q == 2'h1) begin
              mack_q <= ~sda_f;
              ph_q   <= 2'h2;
            end else if (scl_fall && ph_q == 2'h2) begin
              cnt_q <= 3'h0;
              if (mack_q) begin
                state_q <= ST_RDATA;
                oe_q    <= ~rd_byte[7];
                obuf_q  <= {rd_byte[6:0], 1'b0};
                addr_q  <= addr_q + ADDR_ONE;
              end else begin
                // No acknowledge: release and wait for the stop.
                state_q <= ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= ST_IDLE;
            oe_q    <= 1'b0;
          end
        endcase
      end
    end
  end

  // The page bit of the last device address word, kept for the
  // word address that follows it.

  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      dev_page_q <= 1'b0;
    end else if (byte_end && state_q == ST_DEVADR) begin
      dev_page_q <= rx_byte[`TWEEP_DEV_PAGE];
    end
  end

  // Page buffer collects write data until the stop; it needs no reset
  // because the valid bits say which entries are live.
  always @(posedge clk_in) begin
    if (byte_end && state_q == ST_WDATA) begin
      pbuf_q[addr_q[`TWEEP_PAGE_W-1:0]] <= rx_byte;
    end
  end

  // Commit of the live page entries at the stop. Protected upper half
  // entries are simply skipped, so the master still sees acknowledges.
  integer i;

  always @(posedge clk_in) begin
    if (commit && !(wp_f && addr_q[`TWEEP_ADDR_W-1])) begin
      for (i = 0; i < `TWEEP_PAGE_BYTES; i = i + 1) begin
        if (valid_q[i]) begin
          mem_q[{addr_q[`TWEEP_ADDR_W-1:`TWEEP_PAGE_W],
                 i[`TWEEP_PAGE_W-1:0]}] <= pbuf_q[i];
        end
      end
    end
  end

  // Standby: idle protocol state with no internal write pending.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= (state_q == ST_IDLE) & ~busy & ~wr_go_q &
                   ~commit;
    end
  end

  // Open drain: the data output is always low and only the enable moves.
  assign sda_out     = 1'b0;
  assign sda_oe_out  = oe_q;
  assign busy_out    = busy;
  assign standby_out = standby_q;

endmodule

`default_nettype wire

// File: logic/tweep_defines.vh
`ifndef TWEEP_DEFINES_VH
`define TWEEP_DEFINES_VH

// Array geometry: 512 bytes, 16-byte write pages.
`define TWEEP_ADDR_W      9
`define TWEEP_PAGE_W      4
`define TWEEP_PAGE_BYTES  16
`define TWEEP_PBUF_RST    16'h0000

// Device address word layout, most significant bit first on the wire.
`define TWEEP_DEV_TYPE    4'ha
`define TWEEP_DEV_TYPE_HI 7
`define TWEEP_DEV_TYPE_LO 4
`define TWEEP_DEV_CSH_BIT 3
`define TWEEP_DEV_CSL_BIT 2
`define TWEEP_DEV_PAGE    1
`define TWEEP_DEV_RW      0

// Last bit index of a serial word and the address counter reset value.
`define TWEEP_BIT_LAST    3'h7
`define TWEEP_WADDR_RST   9'h000

// Self-timed write cycle: figure in milliseconds, clock in MHz.
`define TWEEP_TWR_MS      10
`define TWEEP_CLK_MHZ     100
`define TWEEP_TWR_CYC     (`TWEEP_TWR_MS * 1000 * `TWEEP_CLK_MHZ)
`define TWEEP_TWR_CW      20

`endif

// File: logic/tweep_sync.v
`timescale 1ns/1ns
`default_nettype none

// Three-stage synchroniser per pin; the output follows only when the
// second and third stages agree, which rejects single-sample glitches.
module tweep_sync #(
  parameter             WIDTH = 5,
  parameter [WIDTH-1:0] INIT  = {WIDTH{1'b1}}
) (
  input  wire             clk_in,
  input  wire             rstn_in,
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] level_out
);

  genvar g;

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : bit_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;

      // Stage one feeds stage two only.
      always @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
          s1_q  <= INIT[g];
          s2_q  <= INIT[g];
          s3_q  <= INIT[g];
          lvl_q <= INIT[g];
        end else begin
          s1_q <= pin_in[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end

      assign level_out[g] = lvl_q;
    end
  endgenerate

endmodule

`default_nettype wire

// File: logic/tweep_wrtimer.v
`timescale 1ns/1ns
`default_nettype none

// Down-counter that times the internal nonvolatile write cycle.
module tweep_wrtimer #(
  parameter CYCLES = 1000000,
  parameter CW     = 20
) (
  input  wire clk_in,
  input  wire rstn_in,
  input  wire start_in,
  output wire busy_out
);

  localparam [CW-1:0] LOAD = CYCLES[CW-1:0];
  localparam [CW-1:0] ONE  = {{(CW-1){1'b0}}, 1'b1};

  reg [CW-1:0] count_q;

  // A new start reloads; otherwise count down to zero and stop.
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      count_q <= {CW{1'b0}};
    end else if (start_in) begin
      count_q <= LOAD;
    end else if (count_q != {CW{1'b0}}) begin
      count_q <= count_q - ONE;
    end
  end

  assign busy_out = (count_q != {CW{1'b0}});

endmodule

`default_nettype wire

// File: verif/tweep_checker.sv
`timescale 1ns/1ns
`default_nettype none

// Watches the target's pins; sees only what the top module shows.
module tweep_checker #(
  parameter TWR_CYCLES = 1000000,
  parameter TWR_CW     = 20
) (
  input wire clk_in,
  input wire rstn_in,
  input wire scl_in,
  input wire sda_in,
  input wire sda_out,
  input wire sda_oe_out,
  input wire chip_select_pin_high_in,
  input wire chip_select_pin_low_in,
  input wire wp_in,
  input wire busy_out,
  input wire standby_out
);
  logic [TWR_CW:0] busy_cnt_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Counts busy cycles; one spare bit so an overlong cycle cannot wrap.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in)
      busy_cnt_q <= '0;
    else if (busy_out)
      busy_cnt_q <= busy_cnt_q + 1'b1;
    else
      busy_cnt_q <= '0;
  end

  a_drive_low_only: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_pull_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in)
    else $error("data pulled low while clock high");
  a_ack_holds: assert property ($rose(sda_oe_out) |-> sda_oe_out[*8])
    else $error("acknowledge released too early");
  a_busy_silent: assert property (busy_out |-> !sda_oe_out)
    else $error("device answered during write cycle");
  a_busy_length: assert property (
    $fell(busy_out) |-> busy_cnt_q == TWR_CYCLES)
    else $error("write cycle length wrong");
  a_busy_on_stop: assert property (
    $rose(busy_out) |-> scl_in && sda_in)
    else $error("write cycle began without a stop");
  a_standby_busy: assert property (busy_out |-> !standby_out)
    else $error("standby while writing");
  a_standby_quiet: assert property (sda_oe_out |-> !standby_out)
    else $error("standby while driving data");
  a_reset_idle: assert property (
    $rose(rstn_in) |-> standby_out && !busy_out && !sda_oe_out)
    else $error("not idle after reset");
endmodule

`default_nettype wire

// File: verif/tweep_master.sv
`timescale 1ns/1ns
`default_nettype none

// Bus master model. SCL idles high and stands still between frames; the
// low phase is longer so data has five clocks of margin on both sides.
module tweep_master (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output var  logic scl_out,
  output var  logic sda_oe_out
);
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  // Every pin move lands just after a rising system clock edge.
  task automatic hold(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // One bit slot of 16 clocks: data moves mid-low, sampled mid-high.
  task automatic bit_x(input logic b, output logic r);
    scl_out <= 1'b0;
    hold(5);
    sda_oe_out <= ~b;
    hold(5);
    scl_out <= 1'b1;
    hold(3);
    r = sda_in;
    hold(3);
  endtask

  task automatic start;
    scl_out <= 1'b0;
    hold(5);
    sda_oe_out <= 1'b0;
    hold(5);
    scl_out <= 1'b1;
    hold(6);
    sda_oe_out <= 1'b1;
    hold(6);
  endtask

  task automatic stop;
    scl_out <= 1'b0;
    hold(5);
    sda_oe_out <= 1'b1;
    hold(5);
    scl_out <= 1'b1;
    hold(6);
    sda_oe_out <= 1'b0;
    hold(12);
  endtask

  // Sends a word most significant bit first and returns the acknowledge.
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask

  // Reads a word; more low asks for no further byte before the stop.
  task automatic recv(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~more, r);
  endtask
endmodule

`default_nettype wire

// File: verif/tweep_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none

module tweep_slave_bench;
  localparam int TWR = 200;
  logic clk_in, rstn_in, wp_in, cs_hi, cs_lo, scl_w, m_oe, ack;
  wire  sda_out, sda_oe_out, busy_out, standby_out, sda_w;
  logic [7:0] d;
  logic [7:0] bad [3] = '{8'hb8, 8'ha0, 8'hac};
  int n_fail, n_checks;

  // Pull-up line: low whenever either party pulls it.
  assign sda_w = ~(m_oe | (sda_oe_out & ~sda_out));

  tweep_slave #(.TWR_CYCLES(TWR), .TWR_CW(20)) tweep_slave_i (
    .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_w), .sda_in(sda_w),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .wp_in(wp_in),
    .chip_select_pin_high_in(cs_hi), .chip_select_pin_low_in(cs_lo),
    .busy_out(busy_out), .standby_out(standby_out));

  tweep_master tweep_master_i (.clk_in(clk_in), .sda_in(sda_w),
    .scl_out(scl_w), .sda_oe_out(m_oe));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] e, logic [7:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  function automatic logic [7:0] dw(input logic p, input logic rw);
    return {4'ha, 1'b1, 1'b0, p, rw};
  endfunction

  // Start, device word for write, then the word address byte.
  task automatic wr_addr(input logic p, input logic [7:0] a);
    tweep_master_i.start;
    tweep_master_i.send(dw(p, 1'b0), ack);
    chk("dev ack", 1'b1, ack);
    tweep_master_i.send(a, ack);
    chk("addr ack", 1'b1, ack);
  endtask

  // Polls with bare address frames; bounded so a dead device cannot hang.
  task automatic poll_ready(input logic first_nack);
    for (int k = 0; k < 12; k++) begin
      tweep_master_i.start;
      tweep_master_i.send(dw(1'b0, 1'b0), ack);
      tweep_master_i.stop;
      if (k == 0 && first_nack) chk("poll busy", 1'b0, ack);
      if (ack) break;
    end
    chk("poll ready", 1'b1, ack);
  endtask

  // Reads one byte from the counter address and does not acknowledge it.
  task automatic rd_cur(output logic [7:0] v);
    tweep_master_i.start;
    tweep_master_i.send(dw(1'b0, 1'b1), ack);
    chk("read ack", 1'b1, ack);
    tweep_master_i.recv(1'b0, v);
    tweep_master_i.stop;
  endtask

  initial begin
    n_fail = 0;
    n_checks = 0;
    rstn_in = 1'b0;
    wp_in = 1'b0;
    cs_hi = 1'b1;
    cs_lo = 1'b0;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    chk("standby", 1'b1, standby_out);
    foreach (bad[i]) begin
      tweep_master_i.start;
      tweep_master_i.send(bad[i], ack);
      tweep_master_i.stop;
      chk("mismatch", 1'b0, ack);
    end
    $display("test address match done");
    wr_addr(1'b1, 8'hff);
    tweep_master_i.send(8'ha5, ack);
    chk("data ack", 1'b1, ack);
    tweep_master_i.stop;
    chk("busy", 1'b1, busy_out);
    poll_ready(1'b1);
    $display("test byte write done");
    // Seventeen bytes from offset 14 wrap and overwrite the first one.
    wr_addr(1'b0, 8'h0e);
    for (int i = 0; i < 17; i++) begin
      tweep_master_i.send(8'h40 + 8'(i), ack);
      chk("page ack", 1'b1, ack);
    end
    tweep_master_i.stop;
    poll_ready(1'b1);
    $display("test page write done");
    wr_addr(1'b1, 8'hff);
    tweep_master_i.start;
    tweep_master_i.send(dw(1'b0, 1'b1), ack);
    tweep_master_i.recv(1'b1, d);
    chk("random read", 8'ha5, d);
    for (int n = 0; n < 15; n++) begin
      tweep_master_i.recv(n < 14, d);
      chk("seq read", 8'h40 + 8'(n == 14 ? 16 : (n + 2) % 16), d);
    end
    tweep_master_i.stop;
    rd_cur(d);
    chk("counter", 8'h41, d);
    repeat (4) @(posedge clk_in);
    chk("standby", 1'b1, standby_out);
    $display("test reads done");
    wp_in <= 1'b1;
    wr_addr(1'b1, 8'hff);
    tweep_master_i.send(8'h3c, ack);
    chk("wp data ack", 1'b1, ack);
    tweep_master_i.stop;
    poll_ready(1'b0);
    wr_addr(1'b1, 8'hff);
    rd_cur(d);
    chk("protected", 8'ha5, d);
    // The lower half stays writable while protection is on.
    wr_addr(1'b0, 8'h20);
    tweep_master_i.send(8'h5a, ack);
    chk("lower data ack", 1'b1, ack);
    tweep_master_i.stop;
    poll_ready(1'b1);
    wr_addr(1'b0, 8'h20);
    rd_cur(d);
    chk("lower write", 8'h5a, d);
    $display("test write protect done");
    close_out;
  end

  // Cuts a hang short; the tests need about a fifth of this span.
  initial begin
    repeat (60000) @(posedge clk_in);
    n_fail++;
    close_out;
  end
endmodule

bind tweep_slave tweep_checker #(.TWR_CYCLES(TWR_CYCLES), .TWR_CW(TWR_CW))
  tweep_checker_i (.clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
  .chip_select_pin_high_in(chip_select_pin_high_in),
  .chip_select_pin_low_in(chip_select_pin_low_in), .wp_in(wp_in),
  .busy_out(busy_out), .standby_out(standby_out));

`default_nettype wire
